// [hdl/cur_pkg.sv]
// Purpose: Shared constants of the camera USB configuration register block.
// Assumes: Byte-wide registers behind the two-wire control bus byte port.
// Notes:   Offsets, field positions, masks and reset values live here only.
package cur_pkg;

  // ****************************************
  // Control bus access
  // ****************************************
  localparam logic [7:0] UNLOCK_CMD   = 8'hE8;  // Command byte on sub-address zero
  localparam logic       SUB_COMMAND  = 1'h0;
  localparam logic       SUB_REGISTER = 1'h1;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_THR_LOW    = 8'h04;
  localparam logic [7:0] OFS_RUN_THR_HI = 8'h05;
  localparam logic [7:0] OFS_PKT_LOW    = 8'h06;
  localparam logic [7:0] OFS_PACE_PKT   = 8'h07;
  localparam logic [7:0] OFS_POWER      = 8'h0B;
  localparam logic [7:0] OFS_GAIN_GEN   = 8'h0C;
  localparam logic [7:0] OFS_GAIN_LEFT  = 8'h0D;
  localparam logic [7:0] OFS_GAIN_RIGHT = 8'h0E;
  localparam logic [7:0] OFS_AUDIO      = 8'h0F;

  // ****************************************
  // Writable bit masks (reserved bits clear)
  // ****************************************
  localparam logic [7:0] MASK_RUN_THR_HI = 8'h87;
  localparam logic [7:0] MASK_POWER      = 8'h2F;
  localparam logic [7:0] MASK_AUDIO      = 8'h7F;
  localparam logic [7:0] MASK_FULL       = 8'hFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RUN_BIT        = 7;
  localparam int THR_HI_MSB     = 2;
  localparam int PKT_HI_MSB     = 1;
  localparam int PACE_LSB       = 2;
  localparam int PWR_PLL_BIT    = 5;
  localparam int PWR_ADC_L_BIT  = 3;
  localparam int PWR_ADC_R_BIT  = 2;
  localparam int PWR_GAIN_L_BIT = 1;
  localparam int PWR_GAIN_R_BIT = 0;
  localparam int AUD_BPS_LSB    = 5;
  localparam int AUD_STEREO_BIT = 4;
  localparam int AUD_ANALOG_BIT = 3;
  localparam int AUD_DCBLK_BIT  = 2;
  localparam int AUD_FMT_LSB    = 0;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int THR_W  = 11;
  localparam int PKT_W  = 10;
  localparam int PACE_W = 6;
  localparam logic [7:0] REG_RESET = 8'h00;  // Everything powered, FIFO idle
  localparam logic [1:0] BPS_RESERVED = 2'h0;

  // ****************************************
  // Packet sequencer states (Gray along idle, arm, send)
  // ****************************************
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ARM  = 2'b01,
    SEQ_SEND = 2'b11
  } cur_seq_type;

endpackage

// [hdl/cur_fifo_if.sv]
// Purpose: Carrier between the register block and its video FIFO.
// Assumes: One clock domain; valid/ready handshake on both sides.
// Notes:   Level is the live word count of the FIFO.
`timescale 1ns/1ps
`default_nettype none
interface cur_fifo_if #(parameter int WIDTH = 9, parameter int DEPTH = 32);
  localparam int LW = $clog2(DEPTH) + 1;

  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic [LW-1:0]    level;

  // Side that fills and drains the buffer
  modport user (output wr_valid, wr_data, rd_ready,
                input  wr_ready, rd_valid, rd_data, level);
  // The buffer itself
  modport store (input  wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, level);
endinterface
`default_nettype wire

// [hdl/cur_fifo.sv]
// Purpose: Synchronous video FIFO with valid/ready on both sides.
// Assumes: Single clock; flush empties the store in one cycle.
// Notes:   Read data is the head word, valid while not empty.
`timescale 1ns/1ps
`default_nettype none
module cur_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  // Control
  input  wire logic  flush,
  // Buffer ports
  cur_fifo_if.store  port
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [LW-1:0]    count_r;
  logic             push;
  logic             pop;

  // Handshakes; full refuses writes so back-pressure reaches the source
  assign port.wr_ready = (count_r != FULL_LEVEL);
  assign port.rd_valid = (count_r != '0);
  assign port.rd_data  = mem[rd_ptr_r];
  assign port.level    = count_r;
  assign push = port.wr_valid && port.wr_ready && !flush;
  assign pop  = port.rd_valid && port.rd_ready && !flush;

  // Storage array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= port.wr_data;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/cur_regs_top.sv]
// Purpose: Configuration registers and video packet pacing of a camera USB device.
// Assumes: Control bus bytes arrive already decoded, synchronous to mclk.
// Notes:   Register pointer is the first byte after each transfer start.
// Notes on behaviour
// - Power register bit 5 high powers the PLL down, low keeps it on.
// - Power register bits 3 and 2 power down left and right ADC.
// - Power register bits 1 and 0 power down left and right gain channels.
// - Fill threshold is 11 bits: register 0x04 low, 0x05 bits 2..0 high.
// - A new frame starts on USB only once FIFO fill reaches threshold.
// - Register 0x05 bit 7 is the FIFO run flag.
// - Packet length is 10 bits: register 0x06 low, 0x07 bits 1..0 high.
// - Packet length sets the number of words in each video packet.
// - Register 0x07 bits 7..2 set spacing between FIFO read pulses, 1 to 63.
// - Audio bits 6..5 give bytes per sample; code zero is reserved.
// - Audio bit 4 selects mono (0) or stereo (1).
// - Audio bit 3 selects serial input (0) or analog inputs (1).
// - Audio bit 2 enables the DC-blocking high-pass stage.
// - Audio bits 1..0 select I2S or LSB-justified 16, 18, 20 bits.
`timescale 1ns/1ps
`default_nettype none
module cur_regs_top #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control bus byte port
  input  wire logic        cb_start,
  input  wire logic        cb_wr,
  input  wire logic        cb_rd,
  input  wire logic        cb_sub,
  input  wire logic [7:0]  cb_wdata,
  output logic      [7:0]  cb_rdata,
  // Analog power-down controls
  output logic             pll_power_down,
  output logic             adc_left_power_down,
  output logic             adc_right_power_down,
  output logic             gain_left_power_down,
  output logic             gain_right_power_down,
  // Audio input interface settings
  output logic      [1:0]  audio_bytes_per_sample,
  output logic             audio_width_valid,
  output logic             audio_stereo,
  output logic             audio_analog_select,
  output logic             audio_dc_block_en,
  output logic      [1:0]  audio_serial_format,
  // Gain-control register contents
  output logic      [7:0]  gain_general,
  output logic      [7:0]  gain_left,
  output logic      [7:0]  gain_right,
  // Video stream in
  input  wire logic        vid_valid,
  input  wire logic [7:0]  vid_data,
  input  wire logic        vid_last,
  output logic             vid_ready,
  // USB isochronous video out
  input  wire logic        usb_ready,
  output logic             usb_valid,
  output logic      [7:0]  usb_data,
  output logic             usb_pkt_end,
  output logic             usb_frame_end,
  output logic             fifo_run
);
  localparam int FW = 9;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] thr_low_r;
  logic [7:0] run_thr_hi_r;
  logic [7:0] pkt_low_r;
  logic [7:0] pace_pkt_r;
  logic [7:0] power_r;
  logic [7:0] gain_gen_r;
  logic [7:0] gain_left_r;
  logic [7:0] gain_right_r;
  logic [7:0] audio_r;
  logic [7:0] ptr_r;
  logic       ptr_loaded_r;
  logic       unlocked_r;
  logic [7:0] rdata_r;

  logic                     reg_wr;
  logic                     reg_rd;
  logic [cur_pkg::THR_W-1:0]  threshold;
  logic [cur_pkg::PKT_W-1:0]  pkt_len;
  logic [cur_pkg::PACE_W-1:0] pacing;
  logic                     run_flag;

  // Register cycles: only after the unlock command, and only once the pointer is set
  assign reg_wr = cb_wr && cb_sub == cur_pkg::SUB_REGISTER && unlocked_r && ptr_loaded_r;
  assign reg_rd = cb_rd && cb_sub == cur_pkg::SUB_REGISTER && unlocked_r && ptr_loaded_r;

  // Unlock latch on the command sub-address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_r <= 1'b0;
    end else if (cb_wr && cb_sub == cur_pkg::SUB_COMMAND) begin
      unlocked_r <= (cb_wdata == cur_pkg::UNLOCK_CMD);
    end
  end

  // Pointer: first byte of a transfer, then auto-increment per access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r        <= 8'h00;
      ptr_loaded_r <= 1'b0;
    end else if (cb_start) begin
      ptr_loaded_r <= 1'b0;
    end else if (cb_wr && cb_sub == cur_pkg::SUB_REGISTER && unlocked_r && !ptr_loaded_r) begin
      ptr_r        <= cb_wdata;
      ptr_loaded_r <= 1'b1;
    end else if (reg_wr || reg_rd) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // Register writes; masks keep reserved bits at zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thr_low_r    <= cur_pkg::REG_RESET;
      run_thr_hi_r <= cur_pkg::REG_RESET;
      pkt_low_r    <= cur_pkg::REG_RESET;
      pace_pkt_r   <= cur_pkg::REG_RESET;
      power_r      <= cur_pkg::REG_RESET;
      gain_gen_r   <= cur_pkg::REG_RESET;
      gain_left_r  <= cur_pkg::REG_RESET;
      gain_right_r <= cur_pkg::REG_RESET;
      audio_r      <= cur_pkg::REG_RESET;
    end else if (reg_wr) begin
      unique case (ptr_r)
        cur_pkg::OFS_THR_LOW:    thr_low_r    <= cb_wdata;
        cur_pkg::OFS_RUN_THR_HI: run_thr_hi_r <= cb_wdata & cur_pkg::MASK_RUN_THR_HI;
        cur_pkg::OFS_PKT_LOW:    pkt_low_r    <= cb_wdata;
        cur_pkg::OFS_PACE_PKT:   pace_pkt_r   <= cb_wdata & cur_pkg::MASK_FULL;
        cur_pkg::OFS_POWER:      power_r      <= cb_wdata & cur_pkg::MASK_POWER;
        cur_pkg::OFS_GAIN_GEN:   gain_gen_r   <= cb_wdata;
        cur_pkg::OFS_GAIN_LEFT:  gain_left_r  <= cb_wdata;
        cur_pkg::OFS_GAIN_RIGHT: gain_right_r <= cb_wdata;
        cur_pkg::OFS_AUDIO:      audio_r      <= cb_wdata & cur_pkg::MASK_AUDIO;
        default: ;  // Unmapped offsets drop the byte
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (ptr_r)
        cur_pkg::OFS_THR_LOW:    rdata_r <= thr_low_r;
        cur_pkg::OFS_RUN_THR_HI: rdata_r <= run_thr_hi_r;
        cur_pkg::OFS_PKT_LOW:    rdata_r <= pkt_low_r;
        cur_pkg::OFS_PACE_PKT:   rdata_r <= pace_pkt_r;
        cur_pkg::OFS_POWER:      rdata_r <= power_r;
        cur_pkg::OFS_GAIN_GEN:   rdata_r <= gain_gen_r;
        cur_pkg::OFS_GAIN_LEFT:  rdata_r <= gain_left_r;
        cur_pkg::OFS_GAIN_RIGHT: rdata_r <= gain_right_r;
        cur_pkg::OFS_AUDIO:      rdata_r <= audio_r;
        default:                 rdata_r <= 8'h00;
      endcase
    end
  end
  assign cb_rdata = rdata_r;

  // ****************************************
  // Field decode
  // ****************************************
  // Power-down controls straight from the stored register bits
  assign pll_power_down        = power_r[cur_pkg::PWR_PLL_BIT];
  assign adc_left_power_down   = power_r[cur_pkg::PWR_ADC_L_BIT];
  assign adc_right_power_down  = power_r[cur_pkg::PWR_ADC_R_BIT];
  assign gain_left_power_down  = power_r[cur_pkg::PWR_GAIN_L_BIT];
  assign gain_right_power_down = power_r[cur_pkg::PWR_GAIN_R_BIT];

  // Audio interface selections
  assign audio_bytes_per_sample = audio_r[cur_pkg::AUD_BPS_LSB +: 2];
  assign audio_stereo           = audio_r[cur_pkg::AUD_STEREO_BIT];
  assign audio_analog_select    = audio_r[cur_pkg::AUD_ANALOG_BIT];
  assign audio_dc_block_en      = audio_r[cur_pkg::AUD_DCBLK_BIT];
  assign audio_serial_format    = audio_r[cur_pkg::AUD_FMT_LSB +: 2];
  assign gain_general           = gain_gen_r;
  assign gain_left              = gain_left_r;
  assign gain_right             = gain_right_r;

  // Flag the reserved sample width so the audio path can hold off
  logic width_ok_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      width_ok_r <= 1'b0;
    end else begin
      width_ok_r <= (audio_r[cur_pkg::AUD_BPS_LSB +: 2] != cur_pkg::BPS_RESERVED);
    end
  end
  assign audio_width_valid = width_ok_r;

  // Video settings
  assign threshold = {run_thr_hi_r[cur_pkg::THR_HI_MSB:0], thr_low_r};
  assign pkt_len   = {pace_pkt_r[cur_pkg::PKT_HI_MSB:0], pkt_low_r};
  assign pacing    = pace_pkt_r[cur_pkg::PACE_LSB +: cur_pkg::PACE_W];
  assign run_flag  = run_thr_hi_r[cur_pkg::RUN_BIT];
  assign fifo_run  = run_flag;

  // ****************************************
  // Video FIFO
  // ****************************************
  cur_fifo_if #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) fif ();

  // An inactive FIFO is held empty; settings may then change safely
  cur_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flush (!run_flag),
    .port  (fif.store)
  );
  assign fif.wr_valid = vid_valid && run_flag;
  assign fif.wr_data  = {vid_last, vid_data};
  assign vid_ready    = fif.wr_ready && run_flag;

  // ****************************************
  // Packet sequencer
  // ****************************************
  cur_pkg::cur_seq_type       state_r;
  logic [cur_pkg::PACE_W-1:0] pace_cnt_r;
  logic [cur_pkg::PKT_W-1:0]  word_cnt_r;
  logic [cur_pkg::PACE_W-1:0] pace_reload;
  logic                       fill_reached;
  logic                       pop;
  logic                       zero_pkt;
  logic                       pkt_done;
  logic                       frame_done;
  logic [7:0]                 usb_data_r;
  logic                       usb_valid_r;
  logic                       pkt_end_r;
  logic                       frame_end_r;

  // Fill level widened to threshold width; the FIFO never exceeds its depth
  assign fill_reached = ({{(cur_pkg::THR_W - LW){1'b0}}, fif.level} >= threshold);
  // Spacing of zero is treated as one pulse per cycle
  assign pace_reload  = (pacing == '0) ? '0 : pacing - 1'b1;
  assign zero_pkt     = (pkt_len == '0);
  assign pop          = (state_r == cur_pkg::SEQ_SEND) && (pace_cnt_r == '0)
                        && usb_ready && !zero_pkt;
  assign fif.rd_ready = pop;
  assign pkt_done     = pop && fif.rd_valid && (word_cnt_r + 1'b1 == pkt_len);
  assign frame_done   = pop && fif.rd_valid && fif.rd_data[FW-1];

  // Frame state: wait for threshold, then stream until the frame ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cur_pkg::SEQ_IDLE;
    end else if (!run_flag) begin
      state_r <= cur_pkg::SEQ_IDLE;
    end else begin
      unique case (state_r)
        cur_pkg::SEQ_IDLE: state_r <= cur_pkg::SEQ_ARM;
        cur_pkg::SEQ_ARM: begin
          if (fill_reached) begin
            state_r <= cur_pkg::SEQ_SEND;
          end
        end
        cur_pkg::SEQ_SEND: begin
          if (frame_done) begin
            state_r <= cur_pkg::SEQ_ARM;
          end
        end
        default: state_r <= cur_pkg::SEQ_IDLE;  // Code 10 is illegal
      endcase
    end
  end

  // Read pulse pacing; zero-length packets also consume one period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pace_cnt_r <= '0;
    end else if (state_r != cur_pkg::SEQ_SEND) begin
      pace_cnt_r <= '0;
    end else if (pace_cnt_r != '0) begin
      pace_cnt_r <= pace_cnt_r - 1'b1;
    end else if ((pop && fif.rd_valid) || (zero_pkt && usb_ready)) begin
      pace_cnt_r <= pace_reload;
    end
  end

  // Word position within the packet; a frame end also closes the packet
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_cnt_r <= '0;
    end else if (state_r != cur_pkg::SEQ_SEND || pkt_done || frame_done) begin
      word_cnt_r <= '0;
    end else if (pop && fif.rd_valid) begin
      word_cnt_r <= word_cnt_r + 1'b1;
    end
  end

  // USB output registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      usb_valid_r <= 1'b0;
      usb_data_r  <= 8'h00;
      pkt_end_r   <= 1'b0;
      frame_end_r <= 1'b0;
    end else begin
      usb_valid_r <= pop && fif.rd_valid;
      pkt_end_r   <= pkt_done || frame_done || ((state_r == cur_pkg::SEQ_SEND)
                     && zero_pkt && usb_ready && pace_cnt_r == '0);
      frame_end_r <= frame_done;
      if (pop && fif.rd_valid) begin
        usb_data_r <= fif.rd_data[7:0];
      end
    end
  end
  assign usb_valid     = usb_valid_r;
  assign usb_data      = usb_data_r;
  assign usb_pkt_end   = pkt_end_r;
  assign usb_frame_end = frame_end_r;
endmodule
`default_nettype wire

// [dv/cur_regs_props.sv]
// Purpose: Port-level checks of the configuration register block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound onto each instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module cur_regs_props #(parameter int FIFO_DEPTH = 32) (
  // Clock, reset and control bus
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cb_wr,
  input wire logic       cb_rd,
  input wire logic [7:0] cb_rdata,
  // Settings
  input wire logic       pll_power_down,
  input wire logic       adc_left_power_down,
  input wire logic       adc_right_power_down,
  input wire logic       gain_left_power_down,
  input wire logic       gain_right_power_down,
  input wire logic [1:0] audio_bytes_per_sample,
  input wire logic       audio_width_valid,
  input wire logic       audio_stereo,
  input wire logic       audio_analog_select,
  input wire logic       audio_dc_block_en,
  input wire logic [1:0] audio_serial_format,
  // Video path
  input wire logic       vid_ready,
  input wire logic       usb_ready,
  input wire logic       usb_valid,
  input wire logic [7:0] usb_data,
  input wire logic       usb_frame_end,
  input wire logic       fifo_run
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****
  // Assertions
  // ****
  a_width_lag: assert property (audio_width_valid == (|$past(audio_bytes_per_sample)))
    else $error("width flag does not follow sample size");
  a_power_hold: assert property (!$past(cb_wr) |-> $stable({pll_power_down,
    adc_left_power_down, adc_right_power_down, gain_left_power_down, gain_right_power_down}))
    else $error("power control moved without a write");
  a_audio_hold: assert property (!$past(cb_wr) |-> $stable({audio_bytes_per_sample,
    audio_stereo, audio_analog_select, audio_dc_block_en, audio_serial_format}))
    else $error("audio setting moved without a write");
  a_run_hold: assert property (!$past(cb_wr) |-> $stable(fifo_run))
    else $error("run flag moved without a write");
  a_ready_run: assert property (vid_ready |-> fifo_run)
    else $error("stream accepted while FIFO inactive");
  // Two cycles of slack: a pop launched as the flag falls still lands
  a_idle_quiet: assert property (!fifo_run && !$past(fifo_run) && !$past(fifo_run, 2)
    |-> !usb_valid) else $error("USB word while FIFO inactive");
  a_frame_word: assert property (usb_frame_end |-> usb_valid ##1 !usb_valid)
    else $error("frame end word not alone");
  a_pop_ready: assert property (usb_valid |-> $past(usb_ready))
    else $error("word sent while sink not ready");
  a_data_hold: assert property (!usb_valid |-> $stable(usb_data))
    else $error("USB data moved without a word");
  a_rdata_hold: assert property (!$past(cb_rd) |-> $stable(cb_rdata))
    else $error("read data moved without a read");
endmodule
bind cur_regs_top cur_regs_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .mclk, .rst_n, .cb_wr, .cb_rd, .cb_rdata, .pll_power_down, .adc_left_power_down,
  .adc_right_power_down, .gain_left_power_down, .gain_right_power_down,
  .audio_bytes_per_sample, .audio_width_valid, .audio_stereo, .audio_analog_select,
  .audio_dc_block_en, .audio_serial_format, .vid_ready, .usb_ready, .usb_valid,
  .usb_data, .usb_frame_end, .fifo_run
);
`default_nettype wire

// [dv/cur_mcu.sv]
// Purpose: Controlling microcontroller on the control bus byte port.
// Assumes: One strobe per byte, launched just after a rising edge.
// Notes:   Data line is scrambled once a byte is taken.
`timescale 1ns/1ps
`default_nettype none
module cur_mcu (
  // Clock and read data
  input  wire logic [7:0] cb_rdata,
  input  wire logic       mclk,
  // Control bus strobes
  output logic            cb_start,
  output logic            cb_wr,
  output logic            cb_rd,
  output logic            cb_sub,
  output logic [7:0]      cb_wdata
);
  // Idle bus from time zero
  initial begin
    cb_start = 1'b0;
    cb_wr    = 1'b0;
    cb_rd    = 1'b0;
    cb_sub   = 1'b0;
    cb_wdata = 8'h00;
  end
  // One byte; inverse left behind so a stale byte never looks valid
  task automatic put(input logic s, input logic [7:0] d);
    @(posedge mclk);
    cb_wr    <= 1'b1;
    cb_sub   <= s;
    cb_wdata <= d;
    @(posedge mclk);
    cb_wr    <= 1'b0;
    cb_wdata <= ~d;
  endtask
  // Command byte, transfer start, register pointer
  task automatic xfer(input logic [7:0] a, input logic [7:0] key);
    put(1'b0, key);
    @(posedge mclk);
    cb_start <= 1'b1;
    @(posedge mclk);
    cb_start <= 1'b0;
    put(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 8'hE8);
    put(1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(a, 8'hE8);
    @(posedge mclk);
    cb_rd  <= 1'b1;
    cb_sub <= 1'b1;
    @(posedge mclk);
    cb_rd <= 1'b0;
    @(negedge mclk);
    d = cb_rdata;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: Self-checking bench of the configuration register block.
// Assumes: 20 MHz clock, reset held three cycles.
// Notes:   USB words are logged on falling edges with a cycle stamp.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****
  // Signals
  // ****
  logic       mclk = 1'b0, rst_n = 1'b0, vid_valid = 1'b0, vid_last = 1'b0, usb_ready = 1'b0;
  logic [7:0] vid_data = 8'h00;
  wire        cb_start, cb_wr, cb_rd, cb_sub, pll_power_down, adc_left_power_down;
  wire        adc_right_power_down, gain_left_power_down, gain_right_power_down;
  wire        audio_width_valid, audio_stereo, audio_analog_select, audio_dc_block_en;
  wire        vid_ready, usb_valid, usb_pkt_end, usb_frame_end, fifo_run;
  wire [1:0]  audio_bytes_per_sample, audio_serial_format;
  wire [7:0]  cb_wdata, cb_rdata, gain_general, gain_left, gain_right, usb_data;
  wire [4:0]  pwr = {pll_power_down, adc_left_power_down, adc_right_power_down,
                     gain_left_power_down, gain_right_power_down};
  wire [6:0]  aud = {audio_bytes_per_sample, audio_stereo, audio_analog_select,
                     audio_dc_block_en, audio_serial_format};
  int         err_count = 0, n_tests = 0, cyc = 0;
  logic [9:0] qd[$];
  int         qt[$];
  cur_regs_top dut (.mclk, .rst_n, .cb_start, .cb_wr, .cb_rd, .cb_sub, .cb_wdata, .cb_rdata,
    .pll_power_down, .adc_left_power_down, .adc_right_power_down, .gain_left_power_down,
    .gain_right_power_down, .audio_bytes_per_sample, .audio_width_valid, .audio_stereo,
    .audio_analog_select, .audio_dc_block_en, .audio_serial_format, .gain_general,
    .gain_left, .gain_right, .vid_valid, .vid_data, .vid_last, .vid_ready, .usb_ready,
    .usb_valid, .usb_data, .usb_pkt_end, .usb_frame_end, .fifo_run);
  cur_mcu mcu (.mclk, .cb_rdata, .cb_start, .cb_wr, .cb_rd, .cb_sub, .cb_wdata);
  // Clock and cycle stamp
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // Falling-edge log of one-cycle USB words
  always @(negedge mclk) if (usb_valid === 1'b1) begin
    qd.push_back({usb_frame_end, usb_pkt_end, usb_data});
    qt.push_back(cyc);
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Stream byte held until taken, then scrambled
  task automatic push(input logic [7:0] d, input logic l);
    @(posedge mclk);
    vid_valid <= 1'b1;
    vid_data  <= d;
    vid_last  <= l;
    @(negedge mclk);
    while (vid_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    vid_valid <= 1'b0;
    vid_data  <= ~d;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [7:0] d;
    chk({1'b0, aud}, 8'h00, "audio at reset");
    chk({5'h0, fifo_run, vid_ready, |pwr}, 8'h00, "power and run at reset");
    mcu.rd(8'h04, d);
    chk(d, 8'h00, "threshold at reset");
  endtask
  task automatic t_power;
    logic [7:0] v [6] = '{8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'hFF};
    logic [7:0] d;
    foreach (v[i]) begin
      mcu.wr(8'h0B, v[i]);
      mcu.rd(8'h0B, d);
      chk({3'h0, pwr}, {3'h0, v[i][5], v[i][3:0]}, "power bits");
      chk(d, v[i] & 8'h2F, "power readback");
    end
    mcu.wr(8'h0B, 8'h00);
  endtask
  // Every size code and format code, both levels of each flag
  task automatic t_audio;
    logic [7:0] v, d;
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, 2'(i), i[0], ~i[0], i[1], 2'(i)};
      mcu.wr(8'h0F, v);
      mcu.rd(8'h0F, d);
      chk({1'b0, aud}, v & 8'h7F, "audio fields");
      chk({7'h0, audio_width_valid}, {7'h0, i != 0}, "width valid");
      chk(d, v & 8'h7F, "audio readback");
    end
  endtask
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h10};
    logic [7:0] w [8] = '{8'h5A, 8'h7B, 8'hC3, 8'h9E, 8'hA5, 8'h3C, 8'h81, 8'hFF};
    logic [7:0] e [8] = '{8'h5A, 8'h03, 8'hC3, 8'h9E, 8'hA5, 8'h3C, 8'h81, 8'h00};
    logic [7:0] d;
    foreach (a[i]) mcu.wr(a[i], w[i]);
    foreach (a[i]) begin
      mcu.rd(a[i], d);
      chk(d, e[i], "register readback");
    end
    chk(gain_left ^ gain_right, 8'hBD, "gain outputs");
    mcu.xfer(8'h0C, 8'h00);
    mcu.put(1'b1, 8'h11);
    @(negedge mclk);
    chk(gain_general, 8'hA5, "write while locked");
  endtask
  // Threshold 3, length 2, spacing 2; fill to full while stalled, then drain
  task automatic t_video;
    int n = 0;
    mcu.wr(8'h04, 8'h03);
    mcu.wr(8'h06, 8'h02);
    mcu.wr(8'h07, 8'h08);
    mcu.wr(8'h05, 8'h80);
    usb_ready <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      if (k == 2) begin
        repeat (10) @(posedge mclk);
        chk(8'(qd.size()), 8'h00, "start below threshold");
        usb_ready <= 1'b0;
      end
      push(8'(k), k == 31);
    end
    @(negedge mclk);
    chk({7'h0, vid_ready}, 8'h00, "FIFO full refuses");
    @(posedge mclk);
    usb_ready <= 1'b1;
    while (qd.size() < 32 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk(8'(qd.size()), 8'h20, "word count");
    foreach (qd[k]) begin
      chk(qd[k][7:0], 8'(k), "usb data");
      chk({6'h0, qd[k][9:8]}, {6'h0, k == 31, k[0]}, "packet marks");
      if (k > 0) chk(8'(qt[k] - qt[k-1]), 8'h02, "read spacing");
    end
    @(negedge mclk);
    chk({7'h0, vid_ready}, 8'h01, "FIFO drained");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_power();
    t_audio();
    t_regs();
    t_video();
    wrap_up();
  end
  // Watchdog: tests need about 500 cycles
  initial begin
    #200_000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
